// file: hdl/pl_pkg.sv
// Shared constants for the party-line peripheral controller.
// Assumes a 10 MHz system clock and a word-addressed Avalon-MM register port.
package pl_pkg;

   localparam int ADDR_W  = 8;
   localparam int WORD_W  = 16;
   localparam int NIB_W   = 4;
   localparam int REG_AW  = 3;

   // Control-bus field positions.
   localparam int STAT_LSB     = 8;
   localparam int CMD_IN_BIT   = 12;
   localparam int CMD_OUT_BIT  = 13;
   localparam int CMD_STAT_BIT = 14;

   // Register word indices.
   localparam logic [REG_AW-1:0] REG_CTRL  = 3'h0;
   localparam logic [REG_AW-1:0] REG_PSTAT = 3'h1;
   localparam logic [REG_AW-1:0] REG_TX    = 3'h2;
   localparam logic [REG_AW-1:0] REG_RX    = 3'h3;
   localparam logic [REG_AW-1:0] REG_DONE  = 3'h4;
   localparam logic [REG_AW-1:0] REG_STATE = 3'h5;

   // Field positions inside the registers.
   localparam int CTRL_IRQ_BIT  = 8;
   localparam int CTRL_EN_BIT   = 9;
   localparam int ST_IN_BIT     = 3;
   localparam int ST_OUT_BIT    = 4;
   localparam int ST_STAT_BIT   = 5;
   localparam int ST_RXNEW_BIT  = 6;
   localparam int ST_PRIO_BIT   = 7;

   // Reset values.
   localparam logic [ADDR_W-1:0] OWN_ADDR_RST = 8'h30;
   localparam logic [NIB_W-1:0]  PSTAT_RST    = 4'h0;
   localparam logic [WORD_W-1:0] WORD_RST     = 16'h0000;

   // Timing: the data-card flag and data drive stand for at least this long.
   localparam int CLK_NS        = 100;
   localparam int DATA_FLAG_NS  = 200;
   localparam int DATA_FLAG_CYC = (DATA_FLAG_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_STAT = 3'b001,
      ST_WAIT = 3'b010,
      ST_BUSY = 3'b011,
      ST_SEND = 3'b100,
      ST_DONE = 3'b101
   } pl_state_t;

endpackage

// file: hdl/pl_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is a slow level; bits are not guaranteed to arrive together.
`timescale 1ns/1ns
module pl_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb
   begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q      <= q_nxt;
      end
   end

endmodule

// file: hdl/pl_slave.sv
// Avalon-MM slave handshake: one wait cycle, then completion.
// Assumes the master holds its request until it sees waitrequest low.
`timescale 1ns/1ns
module pl_slave
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] rd_word,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic             commit
);

   logic        wait_nxt;
   logic [31:0] rdata_nxt;

   always_comb
   begin
      wait_nxt  = 1'b1;
      rdata_nxt = readdata;
      if ((read | write) & waitrequest)
         wait_nxt = 1'b0;
      if (read & waitrequest)
         rdata_nxt = rd_word;
      commit = (read | write) & ~waitrequest;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end
      else
      begin
         waitrequest <= wait_nxt;
         readdata    <= rdata_nxt;
      end
   end

endmodule

// file: hdl/party_line_ctrl.sv
// Party-line peripheral controller: device end of the shared control/data bus.
// Assumes bus pins come from another domain; the peripheral is software on Avalon-MM.
//
// Contract
// R1: 8 address, 16 data, 4 command, 4 status lines.
// R2: Start needs command, own address, strobes.
// R3: Decoder and strobes pick latch or drive.
// R4: Done flag only after control strobe falls.
// R5: Drive own address on low control lines.
// R6: Never share control bus with host address.
// R7: Input: drive data and data flag together.
// R8: Output transfers leave data flag unused.
// R9: Status: control bus and control flag only.
// R10: Break priority chain while requesting interrupt.
// R11: Fastest controllers sit highest in chain.
// R12: Host input command sets bit 12.
// R13: Host output command sets bit 13.
// R14: Control card strobe carries address and command.
// R15: Data card strobe announces valid output data.
// R16: Polled host waits for the done flag.
// R17: Bit 14 returns status, not data.
// R18: Status occupies control bits 8 to 11.
// R19: Release control lines when not transmitting.
// R20: New control strobe clears held request first.
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module party_line_ctrl
   import pl_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [REG_AW-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   input  wire logic [WORD_W-1:0] ctl_in, // R1
   output logic      [WORD_W-1:0] ctl_out,
   output logic      [WORD_W-1:0] ctl_oe,
   input  wire logic [WORD_W-1:0] data_in,
   output logic      [WORD_W-1:0] data_out,
   output logic      [WORD_W-1:0] data_oe,
   input  wire logic              encode_ctl,
   input  wire logic              encode_data,
   output logic                   flag_ctl,
   output logic                   flag_data,
   input  wire logic              prio_in,
   output logic                   prio_out
);

   localparam int SW = 2 * WORD_W + 3;

   logic [SW-1:0]     sync_q;
   logic [WORD_W-1:0] ctl_s;
   logic [WORD_W-1:0] data_s;
   logic              enc_c_s;
   logic              enc_d_s;
   logic              prio_s;
   logic              enc_c_q;
   logic              enc_d_q;
   logic              enc_c_rise;
   logic              enc_d_rise;
   logic              commit;
   logic [31:0]       rd_word;

   pl_state_t         state_r;
   pl_state_t         state_nxt;
   logic [ADDR_W-1:0] own_r;
   logic [ADDR_W-1:0] own_nxt;
   logic              irq_r;
   logic              irq_nxt;
   logic              en_r;
   logic              en_nxt;
   logic [NIB_W-1:0]  pstat_r;
   logic [NIB_W-1:0]  pstat_nxt;
   logic [WORD_W-1:0] tx_r;
   logic [WORD_W-1:0] tx_nxt;
   logic [WORD_W-1:0] rx_r;
   logic [WORD_W-1:0] rx_nxt;
   logic              rxnew_r;
   logic              rxnew_nxt;
   logic [2:0]        cmd_r;
   logic [2:0]        cmd_nxt;
   logic [3:0]        cnt_r;
   logic [3:0]        cnt_nxt;
   logic [WORD_W-1:0] ctl_out_nxt;
   logic [WORD_W-1:0] ctl_oe_nxt;
   logic [WORD_W-1:0] data_out_nxt;
   logic [WORD_W-1:0] data_oe_nxt;
   logic              flag_ctl_nxt;
   logic              flag_data_nxt;
   logic              prio_out_nxt;
   logic              hit;
   logic              wr_hit;
   logic              periph_done;
   logic              pending;

   pl_sync #(.W(SW)) u_sync
   (
      .clock (clock),
      .rst   (rst),
      .d     ({prio_in, encode_data, encode_ctl, data_in, ctl_in}),
      .q     (sync_q)
   );

   pl_slave u_slave
   (
      .clock       (clock),
      .rst         (rst),
      .read        (read),
      .write       (write),
      .rd_word     (rd_word),
      .readdata    (readdata),
      .waitrequest (waitrequest),
      .commit      (commit)
   );

   assign ctl_s   = sync_q[WORD_W-1:0];
   assign data_s  = sync_q[2*WORD_W-1:WORD_W];
   assign enc_c_s = sync_q[2*WORD_W];
   assign enc_d_s = sync_q[2*WORD_W+1];
   assign prio_s  = sync_q[2*WORD_W+2];

   // Read mux; unmapped words read as zero.
   always_comb
   begin
      rd_word = 32'h0000_0000;
      unique case (address)
         REG_CTRL:  rd_word = {22'h0, en_r, irq_r, own_r};
         REG_PSTAT: rd_word = {28'h0, pstat_r};
         REG_TX:    rd_word = {16'h0, tx_r};
         REG_RX:    rd_word = {16'h0, rx_r};
         REG_STATE: rd_word = {24'h0, prio_s, rxnew_r, cmd_r, state_r};
         default:   rd_word = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      enc_c_rise = enc_c_s & ~enc_c_q;
      enc_d_rise = enc_d_s & ~enc_d_q;
      wr_hit     = commit & write;
      own_nxt    = own_r;
      irq_nxt    = irq_r;
      en_nxt     = en_r;
      pstat_nxt  = pstat_r;
      tx_nxt     = tx_r;
      rx_nxt     = rx_r;
      rxnew_nxt  = rxnew_r;
      cmd_nxt    = cmd_r;
      cnt_nxt    = cnt_r;
      state_nxt  = state_r;
      if (wr_hit && address == REG_CTRL)
      begin
         own_nxt = writedata[ADDR_W-1:0];
         irq_nxt = writedata[CTRL_IRQ_BIT];
         en_nxt  = writedata[CTRL_EN_BIT];
      end
      if (wr_hit && address == REG_PSTAT)
         pstat_nxt = writedata[NIB_W-1:0];
      if (wr_hit && address == REG_TX)
         tx_nxt = writedata[WORD_W-1:0];
      if (wr_hit && address == REG_STATE && writedata[ST_RXNEW_BIT])
         rxnew_nxt = 1'b0;
      periph_done = wr_hit && address == REG_DONE && writedata[0];
      // Only a command on the enabled device's own address starts work.
      hit = en_r && ctl_s[ADDR_W-1:0] == own_r
            && (ctl_s[CMD_IN_BIT] | ctl_s[CMD_OUT_BIT] | ctl_s[CMD_STAT_BIT]); // R2

      unique case (state_r)
         ST_IDLE: ;
         ST_STAT:
            if (!enc_c_s)
               state_nxt = ST_IDLE;
         ST_WAIT:
            if (enc_d_rise)
            begin
               rx_nxt    = data_s; // R3
               rxnew_nxt = 1'b1;
               state_nxt = ST_BUSY;
            end
         ST_BUSY:
            if (periph_done)
            begin
               cnt_nxt   = 4'(DATA_FLAG_CYC);
               state_nxt = cmd_r[0] ? ST_SEND : ST_DONE; // R3
            end
         ST_SEND:
         begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1)
               state_nxt = ST_DONE;
         end
         ST_DONE: ;
         default:
            state_nxt = ST_IDLE;
      endcase

      // A fresh control strobe drops any held request before the new command.
      if (enc_c_rise)
      begin
         if (hit)
         begin
            cmd_nxt = {ctl_s[CMD_STAT_BIT], ctl_s[CMD_OUT_BIT], ctl_s[CMD_IN_BIT]};
            if (ctl_s[CMD_STAT_BIT])
               state_nxt = ST_STAT; // R17
            else if (ctl_s[CMD_IN_BIT])
               state_nxt = ST_BUSY;
            else
               state_nxt = ST_WAIT;
         end
         else if (state_r == ST_DONE)
            state_nxt = ST_IDLE; // R20
      end

      pending       = state_nxt == ST_DONE && irq_nxt;
      // The done flag waits for the host strobe to drop, and in interrupt mode
      // for priority from above, so two devices never answer at once.
      flag_ctl_nxt  = (state_nxt == ST_STAT && enc_c_s)
                      || (state_nxt == ST_DONE && !enc_c_s && (!irq_nxt || prio_s)); // R4 R6 R9
      flag_data_nxt = state_nxt == ST_SEND; // R7 R8
      prio_out_nxt  = prio_s & ~pending; // R10
      data_out_nxt  = tx_r;
      data_oe_nxt   = {WORD_W{state_nxt == ST_SEND}}; // R7
      ctl_out_nxt   = '0;
      ctl_oe_nxt    = '0; // R19
      if (state_nxt == ST_STAT && enc_c_s)
      begin
         ctl_out_nxt[STAT_LSB +: NIB_W] = pstat_nxt; // R18
         ctl_oe_nxt[STAT_LSB +: NIB_W]  = {NIB_W{1'b1}};
      end
      if (pending && flag_ctl_nxt)
      begin
         ctl_out_nxt[ADDR_W-1:0] = own_nxt; // R5 R6
         ctl_oe_nxt[ADDR_W-1:0]  = {ADDR_W{1'b1}};
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_r   <= ST_IDLE;
         own_r     <= OWN_ADDR_RST;
         irq_r     <= 1'b0;
         en_r      <= 1'b0;
         pstat_r   <= PSTAT_RST;
         tx_r      <= WORD_RST;
         rx_r      <= WORD_RST;
         rxnew_r   <= 1'b0;
         cmd_r     <= 3'h0;
         cnt_r     <= 4'h0;
         enc_c_q   <= 1'b0;
         enc_d_q   <= 1'b0;
         ctl_out   <= WORD_RST;
         ctl_oe    <= WORD_RST;
         data_out  <= WORD_RST;
         data_oe   <= WORD_RST;
         flag_ctl  <= 1'b0;
         flag_data <= 1'b0;
         prio_out  <= 1'b0;
      end
      else
      begin
         state_r   <= state_nxt;
         own_r     <= own_nxt;
         irq_r     <= irq_nxt;
         en_r      <= en_nxt;
         pstat_r   <= pstat_nxt;
         tx_r      <= tx_nxt;
         rx_r      <= rx_nxt;
         rxnew_r   <= rxnew_nxt;
         cmd_r     <= cmd_nxt;
         cnt_r     <= cnt_nxt;
         enc_c_q   <= enc_c_s;
         enc_d_q   <= enc_d_s;
         ctl_out   <= ctl_out_nxt;
         ctl_oe    <= ctl_oe_nxt;
         data_out  <= data_out_nxt;
         data_oe   <= data_oe_nxt;
         flag_ctl  <= flag_ctl_nxt;
         flag_data <= flag_data_nxt;
         prio_out  <= prio_out_nxt;
      end
   end

   default clocking dc @(posedge clock); endclocking
   default disable iff (rst);

   a_start_status: assert property ( // R2
      enc_c_rise && hit && ctl_s[CMD_STAT_BIT] |=> state_r == ST_STAT)
      else $error("status command on own address not taken");
   a_latch_data: assert property ( // R3
      state_r == ST_WAIT && enc_d_rise |=> rx_r == $past(data_s) && rxnew_r)
      else $error("output word not latched on data strobe");
   a_flag_after_enc: assert property ( // R4
      flag_ctl && state_r == ST_DONE |-> !$past(enc_c_s))
      else $error("done flag raised while control strobe high");
   a_addr_drive: assert property ( // R5
      ctl_oe[ADDR_W-1:0] != 8'h00 |-> flag_ctl && ctl_out[ADDR_W-1:0] == own_r)
      else $error("self address driven wrongly");
   a_no_addr_clash: assert property ( // R6
      ctl_oe[ADDR_W-1:0] != 8'h00 |-> !$past(enc_c_s) && irq_r)
      else $error("self address shares bus with host strobe");
   a_input_pair: assert property ( // R7
      $rose(flag_data) |-> (flag_data && data_oe == 16'hFFFF)[*2] ##1 !flag_data)
      else $error("data flag and data drive not paired for two cycles");
   a_output_no_dflag: assert property ( // R8
      state_r == ST_WAIT || state_r == ST_STAT |-> !flag_data && data_oe == 16'h0000)
      else $error("data flag used outside input transfer");
   a_status_ctl_only: assert property ( // R9
      ctl_oe[STAT_LSB +: NIB_W] != 4'h0 |-> flag_ctl && !flag_data
                                           && ctl_out[STAT_LSB +: NIB_W] == pstat_r)
      else $error("status reply touches data card");
   a_prio_break: assert property ( // R10
      state_r == ST_DONE && irq_r |-> !prio_out)
      else $error("priority chain passed while requesting");
   a_release_idle: assert property ( // R19
      state_r == ST_IDLE |-> ctl_oe == 16'h0000)
      else $error("control lines held while idle");
   a_new_strobe_clear: assert property ( // R20
      state_r == ST_DONE && enc_c_rise && !hit |=> state_r == ST_IDLE ##1 !flag_ctl)
      else $error("held request not cleared by new strobe");

   c_status: cover property (state_r == ST_STAT ##[1:20] state_r == ST_IDLE);
   c_input: cover property ($rose(flag_data) ##[1:20] flag_ctl);
   c_output: cover property (state_r == ST_WAIT ##[1:50] state_r == ST_DONE);
   c_irq_addr: cover property (ctl_oe[ADDR_W-1:0] == 8'hFF);

endmodule

// file: verif/host_cards.sv
// Behavioural host control card and data card facing the controller.
// Assumes one bench process calls the tasks; released lines read as idle zero.
`timescale 1ns/1ns
module host_cards
   import pl_pkg::*;
(
   input  wire logic              clock,
   input  wire logic [WORD_W-1:0] ctl_out,
   input  wire logic [WORD_W-1:0] ctl_oe,
   input  wire logic [WORD_W-1:0] data_out,
   input  wire logic [WORD_W-1:0] data_oe,
   input  wire logic              flag_ctl,
   output logic      [WORD_W-1:0] ctl_in,
   output logic      [WORD_W-1:0] data_in,
   output logic                   encode_ctl,
   output logic                   encode_data
);
   logic [WORD_W-1:0] ctl_drv_r = '0;
   logic [WORD_W-1:0] data_drv_r = '0;
   initial
   begin
      encode_ctl = 1'b0;
      encode_data = 1'b0;
   end
   // Wired-OR: a party that lets go leaves the line at its idle level.
   assign ctl_in  = ctl_drv_r | (ctl_out & ctl_oe);
   assign data_in = data_drv_r | (data_out & data_oe);
   // Hold of zero waits for the flag, as a polled host does.
   task automatic send_ctl(input logic [WORD_W-1:0] word, input int hold,
                           output logic [WORD_W-1:0] got);
      int n;
      n = 0;
      @(posedge clock);
      ctl_drv_r <= word;
      @(posedge clock);
      encode_ctl <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while ((hold == 0) ? (flag_ctl !== 1'b1 && n < 60) : (n < hold));
      got = ctl_in;
      ctl_drv_r <= '0;
      encode_ctl <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task automatic send_data(input logic [WORD_W-1:0] word);
      @(posedge clock);
      data_drv_r <= word;
      @(posedge clock);
      encode_data <= 1'b1;
      repeat (4) @(posedge clock);
      encode_data <= 1'b0;
      data_drv_r <= '0;
      repeat (4) @(posedge clock);
   endtask
endmodule

// file: verif/party_line_ctrl_test.sv
// Self-checking bench: random words and status, fixed seed, hand-picked corners.
// Assumes host_cards stands for the far side and software is reached over Avalon-MM.
`timescale 1ns/1ns
module party_line_ctrl_test;
   import pl_pkg::*;
   logic              clock = 1'b0;
   logic              rst = 1'b1;
   logic [REG_AW-1:0] address = '0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [31:0]       writedata = '0;
   logic [31:0]       readdata;
   logic              waitrequest;
   logic [WORD_W-1:0] ctl_in, ctl_out, ctl_oe, data_in, data_out, data_oe;
   logic              encode_ctl, encode_data, flag_ctl, flag_data, prio_out;
   logic              prio_in = 1'b1;
   int                errors = 0;
   int                cmp_count = 0;
   int                cycles = 0;
   int                dflag_cnt = 0;
   int                cflag_cnt = 0;
   int                cflag_mark = 0;
   logic [WORD_W-1:0] dlatch = '0;
   logic [WORD_W-1:0] got;
   logic [31:0]       d, w;
   integer            seed;
   always #50 clock = ~clock;
   party_line_ctrl party_line_ctrl_i (.clock(clock), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .encode_ctl(encode_ctl),
      .encode_data(encode_data), .flag_ctl(flag_ctl), .flag_data(flag_data),
      .prio_in(prio_in), .prio_out(prio_out));
   host_cards host_cards_i (.clock(clock), .ctl_out(ctl_out), .ctl_oe(ctl_oe),
      .data_out(data_out), .data_oe(data_oe), .flag_ctl(flag_ctl), .ctl_in(ctl_in),
      .data_in(data_in), .encode_ctl(encode_ctl), .encode_data(encode_data));
   // The data card latches the bus on every flag cycle, as the real card does.
   always @(posedge clock)
   begin
      cycles++;
      if (flag_ctl === 1'b1)
         cflag_cnt++;
      if (flag_data === 1'b1)
      begin
         dflag_cnt++;
         dlatch <= data_in;
      end
      if (cycles > 5000)
      begin
         errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got_v, input logic [31:0] exp_v);
      cmp_count++;
      if (got_v !== exp_v)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask
   // State word as software should see it with the chain input high.
   function automatic logic [31:0] exp_state(input logic rxnew, input logic [2:0] cmd,
                                             input pl_state_t st);
      exp_state = 32'h0000_0000;
      exp_state[ST_PRIO_BIT] = 1'b1;
      exp_state[ST_RXNEW_BIT] = rxnew;
      exp_state[ST_STAT_BIT:ST_IN_BIT] = cmd;
      exp_state[2:0] = st;
   endfunction
   task automatic chk_bit(input logic got_v, input logic exp_v);
      chk_word({31'h0, got_v}, {31'h0, exp_v});
   endtask
   task automatic bus(input logic [REG_AW-1:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= wd;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50)
         errors++;
   endtask
   task automatic wait_flag();
      int n;
      n = 0;
      while (flag_ctl !== 1'b1 && n < 60)
      begin
         @(posedge clock);
         n++;
      end
      #1;
   endtask
   task automatic done_write();
      bus(REG_DONE, 1'b1, 32'h1, d);
   endtask
   initial
   begin
      seed = 32'h79CA;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      bus(REG_CTRL, 1'b0, 0, d);
      chk_word(d, {24'h0, OWN_ADDR_RST});
      bus(3'h6, 1'b0, 0, d);
      chk_word(d, 32'h0);
      chk_bit(flag_ctl, 1'b0);
      $display("test reset done");
      host_cards_i.send_ctl(16'h1030, 6, got);
      bus(REG_STATE, 1'b0, 0, d);
      chk_word(d & 32'h7, 32'h0);
      bus(REG_CTRL, 1'b1, 32'h230, d);
      host_cards_i.send_ctl(16'h1031, 6, got);
      bus(REG_STATE, 1'b0, 0, d);
      chk_word(d & 32'h7, 32'h0);
      $display("test foreign address done");
      repeat (3)
      begin
         w = $random(seed) & 32'hF;
         bus(REG_PSTAT, 1'b1, w, d);
         cflag_mark = cflag_cnt;
         host_cards_i.send_ctl(16'h4030, 0, got);
         chk_bit(cflag_cnt > cflag_mark, 1'b1);
         chk_word({28'h0, got[11:8]}, w);
         chk_word(dflag_cnt, 0);
      end
      $display("test status done");
      w = $random(seed) & 32'hFFFF;
      bus(REG_TX, 1'b1, w, d);
      fork
         host_cards_i.send_ctl(16'h1030, 40, got);
         begin
            repeat (10) @(posedge clock);
            done_write();
            repeat (6) @(posedge clock);
            chk_bit(flag_ctl, 1'b0);
         end
      join
      wait_flag();
      chk_bit(flag_ctl, 1'b1);
      chk_word(dflag_cnt, DATA_FLAG_CYC);
      chk_word({16'h0, dlatch}, w);
      $display("test input done");
      w = $random(seed) & 32'hFFFF;
      host_cards_i.send_ctl(16'h2030, 6, got);
      chk_bit(flag_ctl, 1'b0);
      host_cards_i.send_data(w[15:0]);
      bus(REG_RX, 1'b0, 0, d);
      chk_word(d, w);
      done_write();
      wait_flag();
      chk_bit(flag_ctl, 1'b1);
      chk_word(dflag_cnt, DATA_FLAG_CYC);
      bus(REG_STATE, 1'b0, 0, d);
      chk_word(d, exp_state(1'b1, 3'h2, ST_DONE));
      bus(REG_STATE, 1'b1, 32'h1 << ST_RXNEW_BIT, d);
      bus(REG_STATE, 1'b0, 0, d);
      chk_word(d, exp_state(1'b0, 3'h2, ST_DONE));
      $display("test output done");
      bus(REG_CTRL, 1'b1, 32'h330, d);
      host_cards_i.send_ctl(16'h1030, 6, got);
      done_write();
      wait_flag();
      chk_word({24'h0, ctl_in[7:0]}, 32'h30);
      repeat (4) @(posedge clock);
      chk_bit(prio_out, 1'b0);
      host_cards_i.send_ctl(16'h1031, 6, got);
      chk_bit(flag_ctl, 1'b0);
      chk_word({16'h0, ctl_in}, 32'h0);
      chk_bit(prio_out, 1'b1);
      prio_in <= 1'b0;
      repeat (5) @(posedge clock);
      chk_bit(prio_out, 1'b0);
      $display("test interrupt chain done");
      complete_run();
   end
endmodule
